// *** logic/ppr_dly_timer.sv ***
// delay timer counting 0.1 s ticks while its run input stays high
`default_nettype none
module ppr_dly_timer (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    // control
    input  wire logic                          tick,
    input  wire logic                          run,
    input  wire logic [ppr_pkg::TIMER_W-1:0]   limit,
    // result
    output logic                               done
);

    typedef struct packed {
        logic [ppr_pkg::TIMER_W-1:0] count;
        logic                        done;
    } ppr_tmr_s;

    ppr_tmr_s tmr_q;
    ppr_tmr_s tmr_d;

    always_comb begin
        tmr_d = tmr_q;
        if (!run) begin
            tmr_d.count = '0;
            tmr_d.done  = 1'b0;
        end else begin
            if (tick && (tmr_q.count != '1)) begin
                tmr_d.count = tmr_q.count + 1'b1;
            end
            tmr_d.done = (tmr_q.count >= limit);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    assign done = tmr_q.done;

endmodule : ppr_dly_timer
`default_nettype wire

// *** logic/ppr_pkg.sv ***
// constants and types shared by the pressure regulator files
`default_nettype none
package ppr_pkg;

    // configuration word: one decimal digit per nibble
    localparam logic [15:0] CFG_WORD_RESET = 16'h1010;
    localparam int          CFG_POL_LSB    = 0;
    localparam int          CFG_SRC_LSB    = 4;
    localparam int          CFG_FB_LSB     = 8;
    localparam int          CFG_SLP_LSB    = 12;

    // digit codes
    localparam logic [3:0] POL_OFF   = 4'h0;
    localparam logic [3:0] POL_POS   = 4'h1;
    localparam logic [3:0] POL_NEG   = 4'h2;
    localparam logic [3:0] SRC_POT   = 4'h0;
    localparam logic [3:0] SRC_DIG   = 4'h1;
    localparam logic [3:0] SRC_PRESS = 4'h2;
    localparam logic [3:0] FB_AI     = 4'h0;
    localparam logic [3:0] SLP_OFF   = 4'h0;
    localparam logic [3:0] SLP_NORM  = 4'h1;
    localparam logic [3:0] SLP_DIST  = 4'h2;

    // scaling: percentages in 0.1 %, gains in 0.01, pressure in 0.01 MPa
    localparam int PCT_FULL    = 1000;
    localparam int GAIN_UNIT   = 100;
    localparam int DELTA_SCALE = 100000;

    // time base: one tick each 0.1 s
    localparam int CLK_HZ      = 20_000_000;
    localparam int TICK_MS     = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W      = 21;
    localparam int TIMER_W     = 14;

    // reset values of the regulator state
    localparam logic [15:0] FREQ_RESET = 16'h0000;

    typedef logic signed [47:0] ppr_wide_t;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_PRESET = 2'b01,
        ST_RUN    = 2'b10,
        ST_SLEEP  = 2'b11
    } ppr_state_e;

endpackage : ppr_pkg
`default_nettype wire

// *** logic/ppr_regulator.sv ***
// closed-loop pressure regulator setting the drive frequency command
// Functional notes
// - units digit: off, positive or negative action
// - positive: feedback above setpoint lowers frequency
// - negative: feedback above setpoint raises frequency
// - tens digit picks potentiometer, digital or pressure
// - hundreds digit picks feedback; analogue only
// - thousands digit: sleep off, normal, disturbed
// - digital setpoint 0.0 to 100.0 percent
// - feedback multiplied by gain before comparison
// - integral keeps accumulating while deviation persists
// - derivative follows change of deviation only
// - output held while deviation inside limit band
// - preset frequency for hold time before regulating
// - normal sleep: high feedback, lower limit, delay
// - wake on polarity-dependent threshold crossing, after delay in normal sleep, at once in disturbed sleep
// - burst fault at or above high threshold
// - burst fault below low threshold
// - sensor range scales pressure feedback
`default_nettype none
module ppr_regulator #(
    parameter int TICK_CYCLES = ppr_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // configuration word, one decimal digit per nibble
    input  wire logic [15:0] cfg_word,
    // setpoint and feedback, 0.1 % units; sensor range scales pressure feedback
    input  wire logic [9:0]  pot_setpoint,
    input  wire logic [9:0]  digital_setpoint,
    input  wire logic [9:0]  feedback_raw,
    input  wire logic [13:0] sensor_range,
    // loop tuning
    input  wire logic [9:0]  fb_gain,
    input  wire logic [8:0]  kp_gain,
    input  wire logic [8:0]  integral_time,
    input  wire logic [6:0]  derivative_time,
    input  wire logic [6:0]  sample_period,
    input  wire logic [7:0]  deviation_limit,
    // start-up preset
    input  wire logic [15:0] preset_freq,
    input  wire logic [13:0] preset_hold,
    // sleep and wake
    input  wire logic [10:0] sleep_threshold,
    input  wire logic [10:0] wake_threshold,
    input  wire logic [13:0] sleep_delay,
    input  wire logic [13:0] wake_delay,
    input  wire logic [13:0] sleep_band,
    // burst detection
    input  wire logic [10:0] burst_delay,
    input  wire logic [10:0] high_threshold,
    input  wire logic [10:0] low_threshold,
    // frequency limits, 0.01 Hz
    input  wire logic [15:0] lower_limit,
    input  wire logic [15:0] upper_limit,
    // results
    output logic [15:0]      freq_cmd,
    output logic             regulating,
    output logic             preset_active,
    output logic             sleeping,
    output logic             pipe_burst_fault
);

    typedef struct packed {
        logic [ppr_pkg::TICK_W-1:0] tick_cnt;
        logic                       tick;
        ppr_pkg::ppr_state_e        st;
        logic [15:0]                u;
        ppr_pkg::ppr_wide_t         e1;
        ppr_pkg::ppr_wide_t         e2;
        logic [15:0]                freq;
        logic                       reg_on;
        logic                       pre_on;
        logic                       slp_on;
        logic                       fault;
    } ppr_reg_s;

    ppr_reg_s q;
    ppr_reg_s d;

    // the divider wraps here, one enable pulse for every 0.1 s
    localparam logic [ppr_pkg::TICK_W-1:0] TICK_LAST =
        ppr_pkg::TICK_W'(TICK_CYCLES - 1);

    logic [3:0] pol;
    logic [3:0] src;
    logic [3:0] slp;
    logic       enabled;
    logic       pos;

    ppr_pkg::ppr_wide_t fb_g;
    ppr_pkg::ppr_wide_t sp_w;
    ppr_pkg::ppr_wide_t fb_w;
    ppr_pkg::ppr_wide_t norm;
    ppr_pkg::ppr_wide_t err_w;
    ppr_pkg::ppr_wide_t abs_err;
    ppr_pkg::ppr_wide_t fb_k;
    ppr_pkg::ppr_wide_t e;
    ppr_pkg::ppr_wide_t per;
    ppr_pkg::ppr_wide_t ti;
    ppr_pkg::ppr_wide_t sum;
    ppr_pkg::ppr_wide_t delta;
    ppr_pkg::ppr_wide_t u_raw;
    ppr_pkg::ppr_wide_t lo_w;
    ppr_pkg::ppr_wide_t hi_w;
    ppr_pkg::ppr_wide_t pre_w;
    logic [15:0]        u_new;
    logic [15:0]        pre_clamped;

    logic in_band;
    logic sleep_cond;
    logic wake_cond;
    logic burst_cond;
    logic pre_done;
    logic sleep_done;
    logic wake_done;
    logic burst_done;
    logic samp_done;
    logic [6:0] per_eff;

    assign pol = cfg_word[ppr_pkg::CFG_POL_LSB +: 4];
    assign src = cfg_word[ppr_pkg::CFG_SRC_LSB +: 4];
    assign slp = cfg_word[ppr_pkg::CFG_SLP_LSB +: 4];
    // hundreds digit: only the analogue feedback exists, reserved code too
    assign enabled = (pol == ppr_pkg::POL_POS) ||
                     (pol == ppr_pkg::POL_NEG);
    assign pos = (pol == ppr_pkg::POL_POS);
    assign per_eff = (sample_period == 7'h00) ? 7'h01 : sample_period;

    // scaling into one common domain
    // both sides share one scale in pressure mode, so the dead band and
    // the thresholds remain ratios of the setpoint in every source mode
    always_comb begin
        fb_g = ppr_pkg::ppr_wide_t'(feedback_raw) *
               ppr_pkg::ppr_wide_t'(fb_gain) /
               ppr_pkg::ppr_wide_t'(ppr_pkg::GAIN_UNIT);
        if (src == ppr_pkg::SRC_PRESS) begin
            // setpoint read as 0.01 MPa, feedback as share of full scale
            sp_w = ppr_pkg::ppr_wide_t'(digital_setpoint) *
                   ppr_pkg::ppr_wide_t'(ppr_pkg::PCT_FULL);
            fb_w = fb_g * ppr_pkg::ppr_wide_t'(sensor_range);
            norm = (sensor_range == 14'h0000) ? ppr_pkg::ppr_wide_t'(1) :
                   ppr_pkg::ppr_wide_t'(sensor_range);
        end else begin
            sp_w = (src == ppr_pkg::SRC_POT) ?
                   ppr_pkg::ppr_wide_t'(pot_setpoint) :
                   ppr_pkg::ppr_wide_t'(digital_setpoint);
            fb_w = fb_g;
            norm = ppr_pkg::ppr_wide_t'(1);
        end
        err_w = pos ? (sp_w - fb_w) : (fb_w - sp_w);
        abs_err = (err_w < 0) ? -err_w : err_w;
        fb_k = fb_w * ppr_pkg::ppr_wide_t'(ppr_pkg::PCT_FULL);
        e = err_w / norm;
    end

    // incremental control law
    // velocity form: only the change is added to the held output, so a
    // clamp at either limit cannot wind the integral term up
    // zero integral time or period would divide by zero; both read as 1
    always_comb begin
        per = ppr_pkg::ppr_wide_t'(per_eff);
        ti  = (integral_time == 9'h000) ? ppr_pkg::ppr_wide_t'(1) :
              ppr_pkg::ppr_wide_t'(integral_time);
        sum = (e - q.e1)
            + (e * per / ti)
            + ((e - (q.e1 <<< 1) + q.e2) *
               ppr_pkg::ppr_wide_t'(derivative_time) / per);
        delta = sum * ppr_pkg::ppr_wide_t'(kp_gain) *
                ppr_pkg::ppr_wide_t'(upper_limit) /
                ppr_pkg::ppr_wide_t'(ppr_pkg::DELTA_SCALE);
        u_raw = ppr_pkg::ppr_wide_t'(q.u) + delta;
        lo_w  = ppr_pkg::ppr_wide_t'(lower_limit);
        hi_w  = ppr_pkg::ppr_wide_t'(upper_limit);
        if (u_raw > hi_w) begin
            u_new = upper_limit;
        end else if (u_raw < lo_w) begin
            u_new = lower_limit;
        end else begin
            u_new = u_raw[15:0];
        end
        pre_w = ppr_pkg::ppr_wide_t'(preset_freq);
        pre_clamped = (pre_w > hi_w) ? upper_limit : preset_freq;
        in_band = (abs_err * ppr_pkg::ppr_wide_t'(ppr_pkg::PCT_FULL)) <=
                  (ppr_pkg::ppr_wide_t'(deviation_limit) * sp_w);
    end

    // sleep, wake and burst conditions
    always_comb begin
        unique case (slp)
            ppr_pkg::SLP_NORM: begin
                sleep_cond = (fb_k > ppr_pkg::ppr_wide_t'(sleep_threshold) *
                              sp_w) && (q.u <= lower_limit);
            end
            ppr_pkg::SLP_DIST: begin
                sleep_cond = (abs_err *
                              ppr_pkg::ppr_wide_t'(ppr_pkg::PCT_FULL)) <=
                             (ppr_pkg::ppr_wide_t'(sleep_band) *
                              sp_w);
            end
            default: begin
                sleep_cond = 1'b0;
            end
        endcase
        if (pos) begin
            wake_cond = fb_k < ppr_pkg::ppr_wide_t'(wake_threshold) *
                        sp_w;
        end else begin
            wake_cond = fb_k > ppr_pkg::ppr_wide_t'(wake_threshold) *
                        sp_w;
        end
        burst_cond = enabled &&
            ((fb_k >= ppr_pkg::ppr_wide_t'(high_threshold) * sp_w) ||
             (fb_k <  ppr_pkg::ppr_wide_t'(low_threshold)  * sp_w));
    end

    // each delay restarts from zero when its condition drops, so a brief
    // excursion never builds up towards a sleep, a wake or a fault
    ppr_dly_timer u_pre_tmr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (q.tick),
        .run     (q.st == ppr_pkg::ST_PRESET),
        .limit   (preset_hold),
        .done    (pre_done)
    );

    ppr_dly_timer u_sleep_tmr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (q.tick),
        .run     ((q.st == ppr_pkg::ST_RUN) && sleep_cond),
        .limit   (sleep_delay),
        .done    (sleep_done)
    );

    ppr_dly_timer u_wake_tmr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (q.tick),
        .run     ((q.st == ppr_pkg::ST_SLEEP) && wake_cond),
        .limit   (wake_delay),
        .done    (wake_done)
    );

    ppr_dly_timer u_burst_tmr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (q.tick),
        .run     (burst_cond),
        .limit   (ppr_pkg::TIMER_W'(burst_delay)),
        .done    (burst_done)
    );

    // the sampling timer clears itself for one cycle after every pulse
    ppr_dly_timer u_samp_tmr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (q.tick),
        .run     ((q.st == ppr_pkg::ST_RUN) && !samp_done),
        .limit   (ppr_pkg::TIMER_W'(per_eff)),
        .done    (samp_done)
    );

    always_comb begin
        d = q;
        // 0.1 s time base
        d.tick = (q.tick_cnt == TICK_LAST);
        d.tick_cnt = d.tick ? '0 : q.tick_cnt + 1'b1;
        // leaving preset or sleep reloads the error history with the
        // present error, so the first update has no false derivative kick
        if (!enabled) begin
            d.st = ppr_pkg::ST_OFF;
        end else begin
            unique case (q.st)
                ppr_pkg::ST_OFF: begin
                    d.st = ppr_pkg::ST_PRESET;
                end
                ppr_pkg::ST_PRESET: begin
                    if (pre_done) begin
                        d.st = ppr_pkg::ST_RUN;
                        d.u  = pre_clamped;
                        d.e1 = e;
                        d.e2 = e;
                    end
                end
                ppr_pkg::ST_RUN: begin
                    if (sleep_done) begin
                        d.st = ppr_pkg::ST_SLEEP;
                    end else if (samp_done) begin
                        d.e1 = e;
                        d.e2 = q.e1;
                        if (!in_band) begin
                            d.u = u_new;
                        end
                    end
                end
                ppr_pkg::ST_SLEEP: begin
                    if ((slp == ppr_pkg::SLP_DIST) ? wake_cond : wake_done) begin
                        d.st = ppr_pkg::ST_RUN;
                        d.u  = lower_limit;
                        d.e1 = e;
                        d.e2 = e;
                    end
                end
            endcase
        end
        // sleep keeps the drive running at zero speed
        unique case (d.st)
            ppr_pkg::ST_OFF:    d.freq = ppr_pkg::FREQ_RESET;
            ppr_pkg::ST_PRESET: d.freq = pre_clamped;
            ppr_pkg::ST_RUN:    d.freq = d.u;
            ppr_pkg::ST_SLEEP:  d.freq = ppr_pkg::FREQ_RESET;
        endcase
        d.reg_on = (d.st == ppr_pkg::ST_RUN);
        d.pre_on = (d.st == ppr_pkg::ST_PRESET);
        d.slp_on = (d.st == ppr_pkg::ST_SLEEP);
        d.fault  = burst_done && burst_cond;
    end

    // regulator state except the delay timer counts in one register, cleared by the reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign freq_cmd         = q.freq;
    assign regulating       = q.reg_on;
    assign preset_active    = q.pre_on;
    assign sleeping         = q.slp_on;
    assign pipe_burst_fault = q.fault;

endmodule : ppr_regulator
`default_nettype wire

// *** verification/ppr_regulator_checker.sv ***
// concurrent checks on the pressure regulator ports
`default_nettype none
module ppr_regulator_checker #(
    parameter int TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // settings
    input wire logic [15:0] cfg_word,
    input wire logic [9:0]  digital_setpoint,
    input wire logic [9:0]  feedback_raw,
    input wire logic [9:0]  fb_gain,
    input wire logic [15:0] preset_freq,
    input wire logic [13:0] preset_hold,
    input wire logic [10:0] burst_delay,
    input wire logic [10:0] high_threshold,
    input wire logic [10:0] low_threshold,
    input wire logic [15:0] lower_limit,
    input wire logic [15:0] upper_limit,
    // results
    input wire logic [15:0] freq_cmd,
    input wire logic        regulating,
    input wire logic        preset_active,
    input wire logic        sleeping,
    input wire logic        pipe_burst_fault
);
    logic        pol_on;
    logic        src_dig;
    logic        burst_cond;
    logic [47:0] fb_x;
    logic [47:0] sp_x;
    int          pre_q;
    int          bur_q;

    assign pol_on = (cfg_word[3:0] == ppr_pkg::POL_POS)
                 || (cfg_word[3:0] == ppr_pkg::POL_NEG);
    assign src_dig = cfg_word[7:4] == ppr_pkg::SRC_DIG;
    assign fb_x = 48'(feedback_raw) * 48'(fb_gain) / 48'h0064 * 48'h03E8;
    assign sp_x = 48'(digital_setpoint);
    assign burst_cond = pol_on && src_dig
                     && (fb_x >= 48'(high_threshold) * sp_x
                     || fb_x < 48'(low_threshold) * sp_x);

    // cycles spent in preset and under a burst condition
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= 0;
            bur_q <= 0;
        end else begin
            pre_q <= preset_active ? pre_q + 1 : 0;
            bur_q <= burst_cond ? bur_q + 1 : 0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_off_idle:
    assert property (!pol_on |=> freq_cmd == 16'h0000 && !regulating
        && !preset_active && !sleeping && !pipe_burst_fault)
        else $error("outputs active with regulation off");
    a_preset_entry:
    assert property (pol_on && !regulating && !preset_active && !sleeping
        |=> preset_active)
        else $error("preset not entered");
    a_preset_value:
    assert property (preset_active |-> freq_cmd == ((preset_freq >
        upper_limit) ? upper_limit : preset_freq))
        else $error("wrong preset frequency");
    a_preset_hold:
    assert property (preset_active ##1 regulating |->
        pre_q >= (int'(preset_hold) - 1) * TICK_CYCLES
        && pre_q <= (int'(preset_hold) + 1) * TICK_CYCLES + 4)
        else $error("preset hold time wrong");
    a_sleep_zero:
    assert property (sleeping |-> freq_cmd == 16'h0000 && !regulating)
        else $error("frequency output while asleep");
    a_run_range:
    assert property (regulating && lower_limit <= preset_freq
        && preset_freq <= upper_limit
        |-> freq_cmd >= lower_limit && freq_cmd <= upper_limit)
        else $error("frequency outside limits");
    a_burst_rise:
    assert property ($rose(pipe_burst_fault) && src_dig |->
        bur_q >= (int'(burst_delay) - 1) * TICK_CYCLES)
        else $error("burst fault raised early");
    a_burst_clear:
    assert property (pipe_burst_fault && src_dig && !burst_cond
        |=> !pipe_burst_fault)
        else $error("burst fault did not clear");
endmodule : ppr_regulator_checker

bind ppr_regulator ppr_regulator_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (.*);
`default_nettype wire

// *** verification/ppr_regulator_tb.sv ***
// self-checking bench for the pressure regulator
`default_nettype none
module ppr_regulator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 10;
    typedef struct {
        logic [15:0] cfg;
        logic [10:0] press;
        int          dir;
    } ppr_row_s;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] cfg_word = 16'h0000;
    logic [10:0] pressure = 11'h0000;
    logic [9:0]  digital_setpoint = 10'h01F4;
    logic [13:0] sensor_range = 14'h03E8;
    logic [7:0]  deviation_limit = 8'h00;
    logic [15:0] preset_freq = 16'h1388;
    logic [10:0] sleep_threshold = 11'h04B0;
    logic [10:0] wake_threshold = 11'h0384;
    logic [13:0] sleep_delay = 14'h0002;
    logic [13:0] sleep_band = 14'h0032;
    logic [10:0] high_threshold = 11'h07D0;
    logic [10:0] low_threshold = 11'h0000;
    logic [15:0] lower_limit = 16'h03E8;
    logic [15:0] upper_limit = 16'h2710;
    logic [9:0]  fb_gain = 10'h064;
    logic [6:0]  derivative_time = 7'h00;
    logic [6:0]  sample_period = 7'h01;
    logic        hit;
    logic [9:0]  feedback_raw;
    logic [15:0] freq_cmd;
    logic        regulating;
    logic        preset_active;
    logic        sleeping;
    logic        pipe_burst_fault;
    logic [2:0]  flags;
    int          fails = 0;
    int          tests_run = 0;
    // direction: 0 off, 1 above preset, 2 below preset
    ppr_row_s rows [7] = '{'{16'h0011, 11'h02BC, 2}, '{16'h0012, 11'h02BC, 1},
        '{16'h0001, 11'h012C, 1}, '{16'h0021, 11'h012C, 1},
        '{16'h0022, 11'h012C, 2}, '{16'h0111, 11'h02BC, 2},
        '{16'h0000, 11'h02BC, 0}};

    assign flags = {pipe_burst_fault, sleeping, regulating};
    always #25 clk_sys = ~clk_sys;

    ppr_sensor_model u_sensor (.*);
    ppr_regulator #(
        .TICK_CYCLES(TC)
    ) u_dut (.*, .pot_setpoint(digital_setpoint), .kp_gain(9'h0C8),
        .integral_time(9'h00A), .preset_hold(sleep_delay),
        .wake_delay(sleep_delay), .burst_delay(sleep_delay[10:0]));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : step

    task automatic wait_hi(input int sel, input int lim);
        for (int n = 0; n < lim && flags[sel] !== 1'b1; n++) begin
            step(1);
        end
    endtask : wait_hi

    task automatic restart(input logic [15:0] cfg);
        cfg_word = 16'h0000;
        step(3);
        cfg_word = cfg;
    endtask : restart

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end

    initial begin
        step(6);
        chk("freq in reset", 16'h0000, freq_cmd);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            pressure = rows[i].press;
            restart(rows[i].cfg);
            step(8 * TC);
            chk("running", {15'h0000, rows[i].dir != 0},
                {15'h0000, regulating});
            case (rows[i].dir)
                0: chk("freq off", 16'h0000, freq_cmd);
                1: chk("rise", 16'h0001,
                       {15'h0000, freq_cmd > preset_freq});
                default: chk("fall", 16'h0001,
                       {15'h0000, freq_cmd < preset_freq});
            endcase
        end
        // dead band at its exact edge, then just outside it
        pressure = 11'h0258;
        deviation_limit = 8'hC8;
        restart(16'h0011);
        step(8 * TC);
        chk("held in band", preset_freq, freq_cmd);
        deviation_limit = 8'hC7;
        step(4 * TC);
        chk("left band", 16'h0001,
            {15'h0000, freq_cmd < preset_freq});
        // high burst at the threshold itself
        high_threshold = 11'h04B0;
        step(TC);
        chk("early fault", 16'h0000, {15'h0000, pipe_burst_fault});
        wait_hi(2, 4 * TC);
        chk("high fault", 16'h0001, {15'h0000, pipe_burst_fault});
        pressure = 11'h0257;
        step(3);
        chk("high clear", 16'h0000, {15'h0000, pipe_burst_fault});
        high_threshold = 11'h07D0;
        low_threshold = 11'h0320;
        pressure = 11'h018F;
        wait_hi(2, 5 * TC);
        chk("low fault", 16'h0001, {15'h0000, pipe_burst_fault});
        pressure = 11'h0190;
        step(3);
        chk("low clear", 16'h0000, {15'h0000, pipe_burst_fault});
        low_threshold = 11'h0000;
        // feedback gain balances the loop, then a step meets the derivative
        fb_gain = 10'h0C8;
        derivative_time = 7'h0A;
        pressure = 11'h00FA;
        restart(16'h0011);
        step(2);
        chk("preset on", 16'h0001, {15'h0000, preset_active});
        chk("preset freq", preset_freq, freq_cmd);
        step(8 * TC - 2);
        chk("gain balance", preset_freq, freq_cmd);
        pressure = 11'h00C8;
        hit = 1'b0;
        repeat (2 * TC) begin
            step(1);
            hit |= (freq_cmd == upper_limit);
        end
        chk("derivative kick", 16'h0001, {15'h0000, hit});
        fb_gain = 10'h064;
        derivative_time = 7'h00;
        // a long sampling period defers the first update
        sample_period = 7'h0A;
        pressure = 11'h02BC;
        restart(16'h0011);
        step(8 * TC);
        chk("period hold", preset_freq, freq_cmd);
        step(6 * TC);
        chk("period step", 16'h0001, {15'h0000, freq_cmd < preset_freq});
        sample_period = 7'h01;
        // normal sleep and delayed wake
        pressure = 11'h02BC;
        restart(16'h1011);
        wait_hi(1, 30 * TC);
        chk("asleep", 16'h0001, {15'h0000, sleeping});
        chk("sleep freq", 16'h0000, freq_cmd);
        pressure = 11'h012C;
        step(TC);
        chk("wake delay", 16'h0001, {15'h0000, sleeping});
        wait_hi(0, 4 * TC);
        chk("wake freq", lower_limit, freq_cmd);
        // disturbed sleep wakes at once
        pressure = 11'h01F4;
        restart(16'h2011);
        wait_hi(1, 30 * TC);
        chk("band sleep", 16'h0001, {15'h0000, sleeping});
        pressure = 11'h012C;
        step(3);
        chk("fast wake", 16'h0001, {15'h0000, regulating});
        // reset in mid-run, then a fresh start
        sys_rst = 1'b1;
        step(1);
        chk("reset freq", 16'h0000, freq_cmd);
        sys_rst = 1'b0;
        wait_hi(0, 6 * TC);
        chk("restart", 16'h0001, {15'h0000, regulating});
        report_and_stop();
    end
endmodule : ppr_regulator_tb
`default_nettype wire

// *** verification/ppr_sensor_model.sv ***
// pressure sensor model feeding the regulator's analogue feedback
`default_nettype none
module ppr_sensor_model (
    // clock
    input  wire logic        clk_sys,
    // pipe pressure, 0.1 % of sensor full scale
    input  wire logic [10:0] pressure,
    // sensor output
    output var  logic [9:0]  feedback_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    initial feedback_raw = 10'h000;
    // the analogue path saturates at full scale
    always @(posedge clk_sys) begin
        feedback_raw <= (pressure > 11'h03E8) ? 10'h3E8 : pressure[9:0];
    end
endmodule : ppr_sensor_model
`default_nettype wire
